// ### hw/core_regs_pkg.sv
// Purpose: Shared constants for the core control register bank
// Assumes: APB byte address is four times the register index
// Notes: Indices are kept as printed; byte address = index * 4
package core_regs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_STACK_POINTER = 8'h81;
  localparam logic [7:0] IDX_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] IDX_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
  localparam logic [7:0] IDX_TIMER_ZERO_LOW = 8'h8a;
  localparam logic [7:0] IDX_TIMER_ONE_LOW = 8'h8b;
  localparam logic [7:0] IDX_TIMER_ZERO_HIGH = 8'h8c;
  localparam logic [7:0] IDX_TIMER_ONE_HIGH = 8'h8d;
  localparam logic [7:0] IDX_CLOCK_DIVIDER_CONTROL = 8'h8e;
  // Power control fields
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int PC_FRAME_ERROR_ENABLE = 6;
  localparam int PC_POWER_DOWN = 1;
  localparam int PC_SLEEP_CPU = 0;
  localparam logic [7:0] PC_WRITE_MASK = 8'hcf;
  localparam logic [7:0] PC_SLEEP_MASK = 8'h03;
  // Timer control fields
  localparam int TC_ONE_OVERFLOW = 7;
  localparam int TC_ONE_RUN = 6;
  localparam int TC_ZERO_OVERFLOW = 5;
  localparam int TC_ZERO_RUN = 4;
  localparam int TC_EXT_ONE_FLAG = 3;
  localparam int TC_EXT_ONE_TYPE = 2;
  localparam int TC_EXT_ZERO_FLAG = 1;
  localparam int TC_EXT_ZERO_TYPE = 0;
  // Timer mode fields
  localparam int TM_ONE_GATE = 7;
  localparam int TM_ONE_COUNTER = 6;
  localparam int TM_ONE_MODE_HI = 5;
  localparam int TM_ONE_MODE_LO = 4;
  localparam int TM_ZERO_GATE = 3;
  localparam int TM_ZERO_COUNTER = 2;
  localparam int TM_ZERO_MODE_HI = 1;
  localparam int TM_ZERO_MODE_LO = 0;
  // Clock divider control fields
  localparam int CK_ONE_FAST = 4;
  localparam int CK_ZERO_FAST = 3;
  localparam logic [7:0] CK_KEEP_MASK = 8'h18;
  // Reset values
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Prescaler: divide by 12 and by 4
  localparam logic [3:0] SLOW_DIV_LAST = 4'hb;
  localparam logic [1:0] FAST_DIV_LAST = 2'h3;
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'h0,
    MODE_FULL16 = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT = 2'h3
  } timer_mode_e;
endpackage

// ### hw/core_timer_power_control_regs.sv
// Purpose: Core control registers, power requests and timer 0/1 counting
// Assumes: Pins synchronous to pclk; APB with zero wait states
// Notes: Writes over APB take priority over counting in the same cycle
//
// Contract
// - Stack pointer register holds top of stack
// - Two bytes form the 16-bit data pointer
// - Baud double bit doubles serial baud
// - Bit 6 makes serial bit 7 frame error
// - Power-down bit stops all clocks
// - Idle bit stops only the processor clock
// - Timer 1 overflow flag set, auto-cleared
// - Timer 0 overflow flag set, auto-cleared
// - Timer 1 run bit starts and stops it
// - Timer 0 run bit starts and stops it
// - External flags set; edge cleared, level follows
// - One trigger type bit per external input
// - Timer 1 gate needs input one high
// - Timer 0 gate needs input zero high
// - Timer 1 counts pin falls when selected
// - Timer 0 counts pin falls when selected
// - Two-bit mode field per timer nibble
// - Four modes: prescaled, 16-bit, reload, split
// - Split: high byte under timer 1 controls
// - Internal clock divided by 4 or 12
`timescale 1ns/10ps
module core_timer_power_control_regs
  import core_regs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic timer_zero_isr_entry,
  input wire logic timer_one_isr_entry,
  input wire logic ext_zero_isr_entry,
  input wire logic ext_one_isr_entry,
  input wire logic wake_event,
  output logic [7:0] stack_pointer,
  output logic [15:0] data_pointer,
  output logic baud_double,
  output logic frame_error_enable,
  output logic cpu_clock_stop,
  output logic all_clock_stop,
  output logic timer_zero_overflow,
  output logic timer_one_overflow,
  output logic ext_irq_zero_flag,
  output logic ext_irq_one_flag
);

  function automatic logic [16:0] timer_step(input timer_mode_e m, input logic [7:0] tl, input logic [7:0] th);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] r;
    c13 = {th, tl[4:0]} + 13'h0001;
    c16 = {th, tl} + 16'h0001;
    r = {1'b0, th, tl};
    unique case (m)
      MODE_PRESCALED: r = {(th == 8'hff) && (tl[4:0] == 5'h1f), c13[12:5], tl[7:5], c13[4:0]};
      MODE_FULL16: r = {({th, tl} == 16'hffff), c16};
      MODE_RELOAD8: r = (tl == 8'hff) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
      MODE_SPLIT: r = {(tl == 8'hff), th, tl + 8'h01};
    endcase
    return r;
  endfunction

  logic [7:0] stack_pointer_reg;
  logic [7:0] data_pointer_low_reg;
  logic [7:0] data_pointer_high_reg;
  logic [7:0] power_control_reg, power_control_next;
  logic [7:0] timer_control_reg, timer_control_next;
  logic [7:0] timer_mode_reg;
  logic [7:0] clock_divider_control_reg;
  logic [7:0] tl0_reg, tl0_next, th0_reg, th0_next;
  logic [7:0] tl1_reg, tl1_next, th1_reg, th1_next;
  logic [3:0] slow_cnt_reg;
  logic [1:0] fast_cnt_reg;
  logic ext_zero_prev_reg, ext_one_prev_reg, cnt_zero_prev_reg, cnt_one_prev_reg;
  logic [31:0] prdata_reg;

  // APB decode; zero wait states, so pready is always high
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire wr_en = access && pwrite;
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  wire hit_sp = aligned && (idx == IDX_STACK_POINTER);
  wire hit_dpl = aligned && (idx == IDX_DATA_POINTER_LOW);
  wire hit_dph = aligned && (idx == IDX_DATA_POINTER_HIGH);
  wire hit_power_control = aligned && (idx == IDX_POWER_CONTROL);
  wire hit_timer_control = aligned && (idx == IDX_TIMER_CONTROL);
  wire hit_timer_mode = aligned && (idx == IDX_TIMER_MODE);
  wire hit_tl0 = aligned && (idx == IDX_TIMER_ZERO_LOW);
  wire hit_tl1 = aligned && (idx == IDX_TIMER_ONE_LOW);
  wire hit_th0 = aligned && (idx == IDX_TIMER_ZERO_HIGH);
  wire hit_th1 = aligned && (idx == IDX_TIMER_ONE_HIGH);
  wire hit_clock_divider_control = aligned && (idx == IDX_CLOCK_DIVIDER_CONTROL);
  wire hit_any = hit_sp || hit_dpl || hit_dph || hit_power_control || hit_timer_control || hit_timer_mode ||
                 hit_tl0 || hit_tl1 || hit_th0 || hit_th1 || hit_clock_divider_control;
  wire wr_sp = wr_en && hit_sp;
  wire wr_dpl = wr_en && hit_dpl;
  wire wr_dph = wr_en && hit_dph;
  wire wr_power_control = wr_en && hit_power_control;
  wire wr_timer_control = wr_en && hit_timer_control;
  wire wr_timer_mode = wr_en && hit_timer_mode;
  wire wr_tl0 = wr_en && hit_tl0;
  wire wr_tl1 = wr_en && hit_tl1;
  wire wr_th0 = wr_en && hit_th0;
  wire wr_th1 = wr_en && hit_th1;
  wire wr_clock_divider_control = wr_en && hit_clock_divider_control;
  wire [7:0] wd = pwdata[7:0];

  wire [7:0] read_byte = hit_sp ? stack_pointer_reg :
                         hit_dpl ? data_pointer_low_reg :
                         hit_dph ? data_pointer_high_reg :
                         hit_power_control ? power_control_reg :
                         hit_timer_control ? timer_control_reg :
                         hit_timer_mode ? timer_mode_reg :
                         hit_tl0 ? tl0_reg :
                         hit_tl1 ? tl1_reg :
                         hit_th0 ? th0_reg :
                         hit_th1 ? th1_reg :
                         hit_clock_divider_control ? clock_divider_control_reg : RST_ZERO;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = prdata_reg;

  // divide by 12 and by 4
  wire tick_slow = (slow_cnt_reg == SLOW_DIV_LAST);
  wire tick_fast = (fast_cnt_reg == FAST_DIV_LAST);
  wire [3:0] slow_cnt_next = tick_slow ? 4'h0 : slow_cnt_reg + 4'h1;
  wire [1:0] fast_cnt_next = fast_cnt_reg + 2'h1;
  wire tick_zero = clock_divider_control_reg[CK_ZERO_FAST] ? tick_fast : tick_slow;
  wire tick_one = clock_divider_control_reg[CK_ONE_FAST] ? tick_fast : tick_slow;

  // Pins are sampled as synchronous, so one stage gives the edge
  wire ext_zero_fall = ext_zero_prev_reg && !ext_irq_pin_zero;
  wire ext_one_fall = ext_one_prev_reg && !ext_irq_pin_one;
  wire cnt_zero_fall = cnt_zero_prev_reg && !count_pin_zero;
  wire cnt_one_fall = cnt_one_prev_reg && !count_pin_one;

  timer_mode_e mode_zero, mode_one;
  assign mode_zero = timer_mode_e'(timer_mode_reg[TM_ZERO_MODE_HI:TM_ZERO_MODE_LO]);
  assign mode_one = timer_mode_e'(timer_mode_reg[TM_ONE_MODE_HI:TM_ONE_MODE_LO]);
  wire split_zero = (mode_zero == MODE_SPLIT);

  // run bit, gated by input zero
  wire enable_zero = timer_control_reg[TC_ZERO_RUN] &&
                     (!timer_mode_reg[TM_ZERO_GATE] || ext_irq_pin_zero);
  // run bit, gated by input one
  wire enable_one = timer_control_reg[TC_ONE_RUN] &&
                    (!timer_mode_reg[TM_ONE_GATE] || ext_irq_pin_one);
  // count pin falls or internal clock
  wire src_zero = timer_mode_reg[TM_ZERO_COUNTER] ? cnt_zero_fall : tick_zero;
  // count pin falls or internal clock
  wire src_one = timer_mode_reg[TM_ONE_COUNTER] ? cnt_one_fall : tick_one;
  wire inc0 = enable_zero && src_zero && !all_clock_stop;
  // timer 1 stops in its own split mode
  wire inc1 = enable_one && src_one && !all_clock_stop && (mode_one != MODE_SPLIT);
  // split high byte is a timer on timer 1 run bit only
  wire inc_th0_split = split_zero && timer_control_reg[TC_ONE_RUN] && tick_one && !all_clock_stop;

  wire [16:0] step0 = timer_step(mode_zero, tl0_reg, th0_reg);
  wire [16:0] step1 = timer_step(mode_one, tl1_reg, th1_reg);
  wire [7:0] th0_split_sum = th0_reg + 8'h01;
  // overflow on wrap, in the counting cycle
  wire ovf_zero = inc0 && step0[16];
  wire ovf_th0_split = inc_th0_split && (th0_reg == 8'hff);
  // While timer 0 is split, timer 1 keeps counting for baud use but owns no flag
  wire ovf_one = split_zero ? ovf_th0_split : (inc1 && step1[16]);

  assign tl0_next = wr_tl0 ? wd : (inc0 ? step0[7:0] : tl0_reg);
  assign th0_next = wr_th0 ? wd :
                    split_zero ? (inc_th0_split ? th0_split_sum : th0_reg) :
                    (inc0 ? step0[15:8] : th0_reg);
  assign tl1_next = wr_tl1 ? wd : (inc1 ? step1[7:0] : tl1_reg);
  assign th1_next = wr_th1 ? wd : (inc1 ? step1[15:8] : th1_reg);

  // Software write, then routine-entry clear, then hardware set
  wire [7:0] timer_control_base = wr_timer_control ? wd : timer_control_reg;
  wire tf1_next = (timer_control_base[TC_ONE_OVERFLOW] && !timer_one_isr_entry) || ovf_one;
  wire tf0_next = (timer_control_base[TC_ZERO_OVERFLOW] && !timer_zero_isr_entry) || ovf_zero;
  // edge flag is sticky, level flag follows pin
  wire ie1_next = timer_control_base[TC_EXT_ONE_TYPE] ?
                  ((timer_control_base[TC_EXT_ONE_FLAG] && !ext_one_isr_entry) || ext_one_fall) : !ext_irq_pin_one;
  wire ie0_next = timer_control_base[TC_EXT_ZERO_TYPE] ?
                  ((timer_control_base[TC_EXT_ZERO_FLAG] && !ext_zero_isr_entry) || ext_zero_fall) : !ext_irq_pin_zero;
  assign timer_control_next = {tf1_next, timer_control_base[TC_ONE_RUN], tf0_next, timer_control_base[TC_ZERO_RUN],
                               ie1_next, timer_control_base[TC_EXT_ONE_TYPE], ie0_next, timer_control_base[TC_EXT_ZERO_TYPE]};

  // a write of the request wins over a wake in the same cycle
  assign power_control_next = wr_power_control ? (wd & PC_WRITE_MASK) :
                              wake_event ? (power_control_reg & ~PC_SLEEP_MASK) : power_control_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer_reg <= RST_STACK_POINTER;
      data_pointer_low_reg <= RST_ZERO;
      data_pointer_high_reg <= RST_ZERO;
      timer_mode_reg <= RST_ZERO;
      clock_divider_control_reg <= RST_ZERO;
    end else begin
      if (wr_sp) stack_pointer_reg <= wd;
      if (wr_dpl) data_pointer_low_reg <= wd;
      if (wr_dph) data_pointer_high_reg <= wd;
      if (wr_timer_mode) timer_mode_reg <= wd;
      if (wr_clock_divider_control) clock_divider_control_reg <= wd & CK_KEEP_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= RST_ZERO;
      timer_control_reg <= RST_ZERO;
      prdata_reg <= '0;
    end else begin
      power_control_reg <= power_control_next;
      timer_control_reg <= timer_control_next;
      if (setup) prdata_reg <= {24'h000000, read_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tl0_reg <= RST_ZERO;
      th0_reg <= RST_ZERO;
      tl1_reg <= RST_ZERO;
      th1_reg <= RST_ZERO;
      slow_cnt_reg <= 4'h0;
      fast_cnt_reg <= 2'h0;
    end else begin
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
      slow_cnt_reg <= slow_cnt_next;
      fast_cnt_reg <= fast_cnt_next;
    end
  end

  // Previous samples idle high, so no edge is seen right after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_zero_prev_reg <= 1'b1;
      ext_one_prev_reg <= 1'b1;
      cnt_zero_prev_reg <= 1'b1;
      cnt_one_prev_reg <= 1'b1;
    end else begin
      ext_zero_prev_reg <= ext_irq_pin_zero;
      ext_one_prev_reg <= ext_irq_pin_one;
      cnt_zero_prev_reg <= count_pin_zero;
      cnt_one_prev_reg <= count_pin_one;
    end
  end

  assign stack_pointer = stack_pointer_reg;
  assign data_pointer = {data_pointer_high_reg, data_pointer_low_reg};
  assign baud_double = power_control_reg[PC_BAUD_DOUBLE];
  // serial bit 7 becomes frame error flag
  assign frame_error_enable = power_control_reg[PC_FRAME_ERROR_ENABLE];
  // idle stops the processor clock only
  assign cpu_clock_stop = power_control_reg[PC_SLEEP_CPU] || power_control_reg[PC_POWER_DOWN];
  assign all_clock_stop = power_control_reg[PC_POWER_DOWN];
  assign timer_zero_overflow = timer_control_reg[TC_ZERO_OVERFLOW];
  assign timer_one_overflow = timer_control_reg[TC_ONE_OVERFLOW];
  assign ext_irq_zero_flag = timer_control_reg[TC_EXT_ZERO_FLAG];
  assign ext_irq_one_flag = timer_control_reg[TC_EXT_ONE_FLAG];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence slow_period_s;
    tick_slow ##12 tick_slow;
  endsequence
  sequence fast_period_s;
    tick_fast ##4 tick_fast;
  endsequence

  sp_write_only_a: assert property (!$stable(stack_pointer) |-> $past(wr_sp))
    else $error("stack pointer changed without a write");
  dptr_pair_a: assert property (wr_dph && !wr_dpl |=> data_pointer[15:8] == $past(wd))
    else $error("data pointer high byte not written");
  baud_follow_a: assert property (wr_power_control |=> baud_double == $past(wd[PC_BAUD_DOUBLE]))
    else $error("baud double not updated");
  frame_sel_a: assert property (wr_power_control |=> frame_error_enable == $past(wd[PC_FRAME_ERROR_ENABLE]))
    else $error("frame error select not updated");
  power_down_a: assert property (wr_power_control && wd[PC_POWER_DOWN] |=> all_clock_stop && cpu_clock_stop)
    else $error("power-down did not stop clocks");
  idle_only_a: assert property (wr_power_control && wd[PC_SLEEP_CPU] && !wd[PC_POWER_DOWN]
                                |=> cpu_clock_stop && !all_clock_stop)
    else $error("idle stopped the wrong clocks");
  tf_one_set_a: assert property (ovf_one |=> timer_one_overflow)
    else $error("timer 1 overflow flag lost");
  tf_zero_set_a: assert property (ovf_zero |=> timer_zero_overflow)
    else $error("timer 0 overflow flag lost");
  tf_zero_clear_a: assert property (timer_zero_isr_entry && !ovf_zero && !wr_timer_control |=> !timer_zero_overflow)
    else $error("timer 0 flag not cleared on entry");
  run_one_off_a: assert property (!timer_control_reg[TC_ONE_RUN] && !wr_tl1 && !wr_th1 |=> $stable(tl1_reg))
    else $error("timer 1 counted while stopped");
  run_zero_off_a: assert property (!timer_control_reg[TC_ZERO_RUN] && !wr_tl0 |=> $stable(tl0_reg))
    else $error("timer 0 counted while stopped");
  level_follow_a: assert property (!timer_control_reg[TC_EXT_ONE_TYPE] && !wr_timer_control
                                   |=> ext_irq_one_flag == !$past(ext_irq_pin_one))
    else $error("level flag does not follow pin");
  edge_catch_a: assert property (timer_control_reg[TC_EXT_ZERO_TYPE] && !wr_timer_control && ext_zero_fall
                                 |=> ext_irq_zero_flag)
    else $error("falling edge on input 0 missed");
  gate_one_a: assert property (timer_mode_reg[TM_ONE_GATE] && !ext_irq_pin_one |-> !inc1)
    else $error("timer 1 counted with gate closed");
  gate_zero_a: assert property (timer_mode_reg[TM_ZERO_GATE] && !ext_irq_pin_zero |-> !inc0)
    else $error("timer 0 counted with gate closed");
  counter_one_a: assert property (timer_mode_reg[TM_ONE_COUNTER] && !cnt_one_fall |-> !inc1)
    else $error("timer 1 counted without a pin fall");
  counter_zero_a: assert property (timer_mode_reg[TM_ZERO_COUNTER] && !cnt_zero_fall |-> !inc0)
    else $error("timer 0 counted without a pin fall");
  mode_store_a: assert property (wr_timer_mode |=> timer_mode_reg == $past(wd))
    else $error("mode register not written");
  full16_wrap_a: assert property (mode_zero == MODE_FULL16 && inc0 && tl0_reg == 8'hff && !wr_tl0 && !wr_th0
                                  |=> tl0_reg == 8'h00 && th0_reg == $past(th0_reg) + 8'h01)
    else $error("16-bit carry wrong");
  split_high_a: assert property (inc_th0_split && !wr_th0 |=> th0_reg == $past(th0_reg) + 8'h01)
    else $error("split high byte did not count");
  slow_div_a: assert property (tick_slow |-> slow_period_s)
    else $error("divide by 12 period wrong");
  fast_div_a: assert property (tick_fast |-> fast_period_s)
    else $error("divide by 4 period wrong");
  wrap_same_a: assert property (inc0 && mode_zero == MODE_FULL16 && {th0_reg, tl0_reg} == 16'hffff
                                && !wr_tl0 && !wr_th0 |=> timer_zero_overflow && {th0_reg, tl0_reg} == 16'h0000)
    else $error("overflow not raised on wrap");
endmodule

// ### tb/core_timer_power_control_regs_bench.sv
// Purpose: Self-checking bench for the core control register bank
// Assumes: APB slave completes when pready is high
// Notes: Reads are queued by the driver and compared by a monitor
`timescale 1ns/10ps
module core_timer_power_control_regs_bench
  import core_regs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic baud_double, frame_error_enable, cpu_clock_stop, all_clock_stop;
  logic t0f, t1f, e0f, e1f, ip0, ip1, cp0, cp1;
  logic [1:0] irq_level, pulse_req;
  logic [4:0] strobes;
  logic [7:0] stack_pointer, d, sp_v, dl_v, dh_v;
  logic [15:0] data_pointer;
  logic [3:0] flags;
  logic [32:0] expq[$];
  logic [32:0] exp_now;
  logic [7:0] zidx [5] = '{IDX_DATA_POINTER_LOW, IDX_DATA_POINTER_HIGH, IDX_POWER_CONTROL, IDX_TIMER_CONTROL,
    IDX_TIMER_MODE};
  logic [7:0] mode_v [3] = '{8'h04, 8'h06, 8'h37};
  logic [7:0] tl_v [3] = '{8'hff, 8'hfe, 8'hff};
  logic [7:0] th_v [3] = '{8'hff, 8'ha5, 8'hff};
  logic [7:0] tl_x [3] = '{8'he0, 8'ha5, 8'h00};
  logic [7:0] th_x [3] = '{8'h00, 8'ha5, 8'hff};
  int n_errors, check_count;
  assign flags = {e1f, e0f, t1f, t0f};

  core_timer_power_control_regs core_timer_power_control_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_zero(ip0), .ext_irq_pin_one(ip1), .count_pin_zero(cp0), .count_pin_one(cp1),
    .timer_zero_isr_entry(strobes[0]), .timer_one_isr_entry(strobes[1]), .ext_zero_isr_entry(strobes[2]),
    .ext_one_isr_entry(strobes[3]), .wake_event(strobes[4]), .stack_pointer(stack_pointer),
    .data_pointer(data_pointer), .baud_double(baud_double), .frame_error_enable(frame_error_enable),
    .cpu_clock_stop(cpu_clock_stop), .all_clock_stop(all_clock_stop), .timer_zero_overflow(t0f),
    .timer_one_overflow(t1f), .ext_irq_zero_flag(e0f), .ext_irq_one_flag(e1f));
  pin_partner pin_partner_i (.pclk(pclk), .presetn(presetn), .irq_level(irq_level), .pulse_req(pulse_req),
    .ext_irq_pin_zero(ip0), .ext_irq_pin_one(ip1), .count_pin_zero(cp0), .count_pin_one(cp1));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task tally_and_finish;
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 33'h0);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h0, {25'h0, e});
  endtask

  task pulse(input int k);
    @(posedge pclk);
    strobes[k] <= 1'b1;
    @(posedge pclk);
    strobes <= 5'h0;
    @(negedge pclk);
  endtask

  task wait_flag(input int i, input logic v);
    int n;
    n = 0;
    while (flags[i] !== v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("flag", {31'h0, v}, {31'h0, flags[i]});
    if (flags[i] !== v) tally_and_finish();
  endtask

  // Monitor takes the oldest queued note at each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_now = expq.pop_front();
      chk("prdata", exp_now[31:0], prdata);
      chk("pslverr", {31'h0, exp_now[32]}, {31'h0, pslverr});
    end
  end

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    strobes = 5'h0;
    irq_level = 2'h3;
    pulse_req = 2'h0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'h85aac9e9));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_STACK_POINTER, RST_STACK_POINTER);
    for (int i = 0; i < 5; i++) rd(zidx[i], RST_ZERO);
    $display("Test reset values done");
    sp_v = 8'($urandom);
    dl_v = 8'($urandom);
    dh_v = 8'($urandom);
    wr(IDX_STACK_POINTER, sp_v);
    wr(IDX_DATA_POINTER_LOW, dl_v);
    wr(IDX_DATA_POINTER_HIGH, dh_v);
    apb(1'b1, 8'h80, 8'h55, 33'h0);
    apb(1'b0, 8'h80, 8'h0, {1'b1, 32'h0});
    rd(IDX_STACK_POINTER, sp_v);
    rd(IDX_DATA_POINTER_HIGH, dh_v);
    @(negedge pclk);
    chk("stack_pointer", {24'h0, sp_v}, {24'h0, stack_pointer});
    chk("data_pointer", {16'h0, dh_v, dl_v}, {16'h0, data_pointer});
    $display("Test pointers done");
    d = 8'($urandom) & 8'hcc;
    wr(IDX_POWER_CONTROL, d);
    rd(IDX_POWER_CONTROL, d);
    @(negedge pclk);
    chk("baud_double", {31'h0, d[7]}, {31'h0, baud_double});
    chk("frame_error_enable", {31'h0, d[6]}, {31'h0, frame_error_enable});
    wr(IDX_POWER_CONTROL, 8'hff);
    rd(IDX_POWER_CONTROL, 8'hcf);
    @(negedge pclk);
    chk("power stops", 32'h3, {30'h0, all_clock_stop, cpu_clock_stop});
    pulse(4);
    rd(IDX_POWER_CONTROL, 8'hcc);
    wr(IDX_POWER_CONTROL, 8'h01);
    @(negedge pclk);
    chk("idle stops", 32'h1, {30'h0, all_clock_stop, cpu_clock_stop});
    pulse(4);
    $display("Test power done");
    for (int t = 0; t < 2; t++) begin
      wr(IDX_CLOCK_DIVIDER_CONTROL, 8'h08);
      wr(IDX_TIMER_MODE, t ? 8'h90 : 8'h09);
      wr(8'(IDX_TIMER_ZERO_LOW + t), 8'hfe);
      wr(8'(IDX_TIMER_ZERO_HIGH + t), 8'hff);
      irq_level[t] <= 1'b0;
      wr(IDX_TIMER_CONTROL, t ? 8'h40 : 8'h10);
      repeat (60) @(posedge pclk);
      @(negedge pclk);
      chk("gated overflow", 32'h0, {31'h0, flags[t]});
      @(posedge pclk);
      irq_level[t] <= 1'b1;
      wait_flag(t, 1'b1);
      pulse(t);
      chk("overflow cleared", 32'h0, {31'h0, flags[t]});
      wr(IDX_TIMER_CONTROL, 8'h00);
    end
    $display("Test timers done");
    wr(IDX_TIMER_MODE, 8'h55);
    wr(IDX_TIMER_ZERO_LOW, 8'h00);
    wr(IDX_TIMER_ONE_LOW, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h50);
    repeat (3) begin
      pulse_req <= 2'h3;
      @(posedge pclk);
      pulse_req <= 2'h0;
      repeat (8) @(posedge pclk);
    end
    wr(IDX_TIMER_CONTROL, 8'h00);
    rd(IDX_TIMER_ZERO_LOW, 8'h03);
    rd(IDX_TIMER_ONE_LOW, 8'h03);
    $display("Test counters done");
    for (int m = 0; m < 3; m++) begin
      wr(IDX_TIMER_MODE, mode_v[m]);
      wr(IDX_TIMER_ZERO_LOW, tl_v[m]);
      wr(IDX_TIMER_ZERO_HIGH, th_v[m]);
      wr(IDX_TIMER_CONTROL, 8'h10);
      repeat ((m == 1) ? 2 : 1) begin
        pulse_req <= 2'h1;
        @(posedge pclk);
        pulse_req <= 2'h0;
        repeat (8) @(posedge pclk);
      end
      @(negedge pclk);
      chk("mode overflow", 32'h1, {31'h0, flags[0]});
      wr(IDX_TIMER_CONTROL, 8'h00);
      rd(IDX_TIMER_ZERO_LOW, tl_x[m]);
      rd(IDX_TIMER_ZERO_HIGH, th_x[m]);
    end
    wr(IDX_TIMER_CONTROL, 8'h40);
    wait_flag(1, 1'b1);
    wr(IDX_TIMER_CONTROL, 8'h00);
    rd(IDX_TIMER_ZERO_HIGH, 8'h00);
    rd(IDX_TIMER_ONE_LOW, 8'h03);
    $display("Test timer modes done");
    for (int i = 0; i < 2; i++) begin
      wr(IDX_TIMER_CONTROL, 8'h05);
      irq_level[i] <= 1'b0;
      wait_flag(2 + i, 1'b1);
      irq_level[i] <= 1'b1;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("edge flag held", 32'h1, {31'h0, flags[2 + i]});
      pulse(2 + i);
      chk("edge flag cleared", 32'h0, {31'h0, flags[2 + i]});
      wr(IDX_TIMER_CONTROL, 8'h00);
      irq_level[i] <= 1'b0;
      wait_flag(2 + i, 1'b1);
      irq_level[i] <= 1'b1;
      wait_flag(2 + i, 1'b0);
    end
    $display("Test external inputs done");
    tally_and_finish();
  end
endmodule

// ### tb/pin_partner.sv
// Purpose: Model of the external interrupt and count pins
// Assumes: Pins are pulled up, so they idle high
// Notes: A count request gives one low pulse three cycles long
`timescale 1ns/10ps
module pin_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] irq_level,
  input wire logic [1:0] pulse_req,
  output logic ext_irq_pin_zero,
  output logic ext_irq_pin_one,
  output logic count_pin_zero,
  output logic count_pin_one
);
  logic [1:0] low_zero_reg;
  logic [1:0] low_one_reg;
  assign ext_irq_pin_zero = irq_level[0];
  assign ext_irq_pin_one = irq_level[1];
  assign count_pin_zero = (low_zero_reg == 2'h0);
  assign count_pin_one = (low_one_reg == 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_zero_reg <= 2'h0;
      low_one_reg <= 2'h0;
    end else begin
      low_zero_reg <= pulse_req[0] ? 2'h3 : (low_zero_reg == 2'h0 ? 2'h0 : low_zero_reg - 2'h1);
      low_one_reg <= pulse_req[1] ? 2'h3 : (low_one_reg == 2'h0 ? 2'h0 : low_one_reg - 2'h1);
    end
  end
endmodule
